// [shared/mlsd_pkg.sv]
// Package for the motor load and stall detector: register map, fields, bus carriers
package mlsd_pkg;

    // ====================================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_VALUE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;

    // ====================================================================
    // Field layout
    localparam int OFFSET_W = 7;
    localparam int VALUE_W = 10;
    localparam int CTRL_OFFSET_LSB = 0;
    localparam int CTRL_FILTER_BIT = 8;
    localparam int VALUE_LSB = 0;
    localparam int VALUE_STALL_BIT = 16;
    localparam int IRQ_W = 2;
    localparam int IRQ_MEAS_BIT = 0;
    localparam int IRQ_STALL_BIT = 1;

    // ====================================================================
    // Reset values and measurement constants
    localparam logic [OFFSET_W-1:0] OFFSET_RST = 7'h00;
    localparam logic FILTER_RST = 1'b0;
    localparam logic [VALUE_W-1:0] VALUE_RST = 10'h3ff;
    localparam logic [VALUE_W-1:0] VALUE_MAX = 10'h3ff;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    localparam int OFFSET_SCALE_LOG2 = 4;
    localparam int FILTER_STEPS_LOG2 = 2;

    // ====================================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } mlsd_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mlsd_axi_rsp_t;

endpackage

// [hdl/mlsd_top.sv]
// Motor load measurement and stall detector with AXI4-Lite register slave
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - A 7-bit signed offset shifts the measurement range and the stall level.
// - Negative offsets raise sensitivity; positive ones up to +63 lower it.
// - Filter bit set: one value per four full steps; clear: no filtering.
// - The load value is a 10-bit unsigned number 0 to 1023 readable by software.
// - Lighter load gives a larger value; zero means the heaviest load.
// - A value of zero raises the stall output: a step has been lost.
// - Unfiltered, the value is refreshed once every full step.
// - The stall output is active high.

module mlsd_top
    import mlsd_pkg::*;
#(
    parameter int SAMPLE_W = VALUE_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire mlsd_axi_req_t axi_req,
    output mlsd_axi_rsp_t axi_rsp,
    input wire logic full_step,
    input wire logic [SAMPLE_W-1:0] load_sample,
    output logic stall_flag_output,
    output logic irq
);

    // ====================================================================
    // State
    typedef struct packed {
        mlsd_axi_rsp_t rsp;
        logic aw_ok;
        logic [ADDR_W-1:0] aw_addr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [OFFSET_W-1:0] load_threshold_offset;
        logic load_filter_enable;
        logic [VALUE_W-1:0] load_measure_value;
        logic stall;
        logic [VALUE_W+FILTER_STEPS_LOG2-1:0] acc;
        logic [FILTER_STEPS_LOG2-1:0] cnt;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
    } mlsd_state_t;

    localparam mlsd_state_t STATE_RST = '{
        rsp: '0,
        aw_ok: 1'b0,
        aw_addr: '0,
        w_ok: 1'b0,
        wdata: '0,
        wstrb: '0,
        load_threshold_offset: OFFSET_RST,
        load_filter_enable: FILTER_RST,
        load_measure_value: VALUE_RST,
        stall: 1'b0,
        acc: '0,
        cnt: '0,
        irq_status: '0,
        irq_mask: IRQ_MASK_RST,
        irq: 1'b0
    };

    mlsd_state_t st_r;
    mlsd_state_t st_nxt;

    // ====================================================================
    // Helpers
    // Raw sample shifted by the scaled offset, clipped to the value range
    function automatic logic [VALUE_W-1:0] shape_sample(
        input logic [SAMPLE_W-1:0] raw,
        input logic [OFFSET_W-1:0] ofs
    );
        logic signed [VALUE_W+3:0] sum;
        sum = $signed({4'h0, raw[VALUE_W-1:0]})
            + ($signed({{4{ofs[OFFSET_W-1]}}, ofs, 3'h0}) <<< (OFFSET_SCALE_LOG2 - 3));
        if (sum < 0) begin
            return '0;
        end else if (sum > $signed({4'h0, VALUE_MAX})) begin
            return VALUE_MAX;
        end else begin
            return sum[VALUE_W-1:0];
        end
    endfunction

    function automatic logic [31:0] read_mux(
        input mlsd_state_t s,
        input logic [ADDR_W-1:0] a
    );
        logic [31:0] d;
        d = '0;
        unique case (a)
            REG_CTRL: begin
                d[CTRL_OFFSET_LSB +: OFFSET_W] = s.load_threshold_offset;
                d[CTRL_FILTER_BIT] = s.load_filter_enable;
            end
            REG_VALUE: begin
                d[VALUE_LSB +: VALUE_W] = s.load_measure_value;
                d[VALUE_STALL_BIT] = s.stall;
            end
            REG_IRQ_STATUS: begin
                d[IRQ_W-1:0] = s.irq_status;
            end
            REG_IRQ_MASK: begin
                d[IRQ_W-1:0] = s.irq_mask;
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a == REG_CTRL) || (a == REG_VALUE)
            || (a == REG_IRQ_STATUS) || (a == REG_IRQ_MASK);
    endfunction

    // ====================================================================
    // Next state
    always_comb begin
        logic do_write;
        logic meas_new;
        logic [VALUE_W-1:0] shaped;
        logic [VALUE_W+FILTER_STEPS_LOG2-1:0] sum4;
        logic [VALUE_W-1:0] new_value;
        logic [IRQ_W-1:0] irq_set;
        logic [IRQ_W-1:0] irq_clr;

        st_nxt = st_r;
        do_write = 1'b0;
        meas_new = 1'b0;
        new_value = st_r.load_measure_value;
        irq_set = '0;
        irq_clr = '0;
        shaped = shape_sample(load_sample, st_r.load_threshold_offset);
        sum4 = st_r.acc + {{FILTER_STEPS_LOG2{1'b0}}, shaped};

        // Write channels are taken independently, in either order
        if (axi_req.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_ok = 1'b1;
            st_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_r.rsp.wready) begin
            st_nxt.w_ok = 1'b1;
            st_nxt.wdata = axi_req.wdata;
            st_nxt.wstrb = axi_req.wstrb;
        end
        if (st_r.rsp.bvalid && axi_req.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end

        do_write = st_r.aw_ok && st_r.w_ok && !st_r.rsp.bvalid;
        if (do_write) begin
            st_nxt.aw_ok = 1'b0;
            st_nxt.w_ok = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = addr_known(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st_r.aw_addr)
                REG_CTRL: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.load_threshold_offset =
                            st_r.wdata[CTRL_OFFSET_LSB +: OFFSET_W];
                    end
                    if (st_r.wstrb[1]) begin
                        st_nxt.load_filter_enable = st_r.wdata[CTRL_FILTER_BIT];
                    end
                end
                REG_IRQ_STATUS: begin
                    if (st_r.wstrb[0]) begin
                        irq_clr = st_r.wdata[IRQ_W-1:0];
                    end
                end
                REG_IRQ_MASK: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.irq_mask = st_r.wdata[IRQ_W-1:0];
                    end
                end
                default: begin
                    irq_clr = '0;
                end
            endcase
        end

        // Read: one outstanding, data latched at address acceptance
        if (st_r.rsp.rvalid && axi_req.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata = read_mux(st_r, axi_req.araddr);
            st_nxt.rsp.rresp = addr_known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Measurement per full step
        if (full_step) begin
            if (st_r.load_filter_enable) begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                st_nxt.acc = sum4;
                if (&st_r.cnt) begin
                    meas_new = 1'b1;
                    new_value = sum4[VALUE_W+FILTER_STEPS_LOG2-1:FILTER_STEPS_LOG2];
                    st_nxt.acc = '0;
                end
            end else begin
                meas_new = 1'b1;
                new_value = shaped;
            end
        end
        // Leaving filtered mode drops a partial average so it never mixes modes
        if (!st_r.load_filter_enable) begin
            st_nxt.acc = '0;
            st_nxt.cnt = '0;
        end

        if (meas_new) begin
            st_nxt.load_measure_value = new_value;
            st_nxt.stall = (new_value == '0);
            irq_set[IRQ_MEAS_BIT] = 1'b1;
            irq_set[IRQ_STALL_BIT] = (new_value == '0);
        end

        // A fresh event outlives a clear in the same cycle
        st_nxt.irq_status = (st_r.irq_status & ~irq_clr) | irq_set;
        st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);

        st_nxt.rsp.awready = !st_nxt.aw_ok;
        st_nxt.rsp.wready = !st_nxt.w_ok;
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
    end

    // ====================================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp = st_r.rsp;
    assign stall_flag_output = st_r.stall;
    assign irq = st_r.irq;

endmodule // mlsd_top

// [bench/mlsd_top_assertions.sv]
// Port checker for the motor load and stall detector
`timescale 1ns/1ps
module mlsd_top_assertions
    import mlsd_pkg::*;
#(
    parameter int SAMPLE_W = VALUE_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire mlsd_axi_req_t axi_req,
    input wire mlsd_axi_rsp_t axi_rsp,
    input wire logic full_step,
    input wire logic [SAMPLE_W-1:0] load_sample,
    input wire logic stall_flag_output,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========
    // Bus steps
    sequence s_wr_both;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready && !axi_rsp.bvalid;
    endsequence
    sequence s_rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    a_write_answer: assert property (s_wr_both |-> ##[1:2] axi_rsp.bvalid)
        else $error("write answer missing");
    a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (s_rd_take |=> axi_rsp.rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data moved");
    a_rd_busy: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken while busy");
    a_rd_done: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("read answer repeated");
    // ==========
    // Stall output moves only with a measurement
    a_stall_rise: assert property ($rose(stall_flag_output) |-> $past(full_step))
        else $error("stall rose without step");
    a_stall_fall: assert property ($fell(stall_flag_output) |-> $past(full_step))
        else $error("stall fell without step");
endmodule // mlsd_top_assertions

bind mlsd_top mlsd_top_assertions #(.SAMPLE_W(SAMPLE_W)) chk_i (.clk(clk), .resetn(resetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .full_step(full_step), .load_sample(load_sample),
    .stall_flag_output(stall_flag_output), .irq(irq));

// [bench/mlsd_motor_model.sv]
// Motor coil stand-in: full steps carrying a raw load sample
`timescale 1ns/1ps
module mlsd_motor_model
    import mlsd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic step_req,
    input wire logic [VALUE_W-1:0] step_load,
    output logic full_step,
    output logic [VALUE_W-1:0] load_sample
);
    // Sample toggles between steps so a stale value is never trusted
    always_ff @(posedge clk) begin
        if (!resetn) begin
            full_step <= 1'b0;
            load_sample <= 10'h000;
        end else begin
            full_step <= step_req;
            load_sample <= step_req ? step_load : ~load_sample;
        end
    end
endmodule // mlsd_motor_model

// [bench/tb_motor_load_stall_detect.sv]
// Self-checking bench for the motor load and stall detector
`timescale 1ns/1ps
module tb_motor_load_stall_detect
    import mlsd_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    mlsd_axi_req_t req = '0;
    mlsd_axi_rsp_t rsp;
    logic step_req = 1'b0;
    logic [VALUE_W-1:0] step_load = 10'h000;
    logic full_step;
    logic [VALUE_W-1:0] load_sample;
    logic stall;
    logic irq;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    // Host keeps offsets at or above minus ten
    logic [6:0] ofs_t [4] = '{7'h76, 7'h3f, 7'h01, 7'h7f};
    logic [9:0] smp_t [4] = '{10'h0a0, 10'h3e8, 10'h064, 10'h00a};
    logic [31:0] exp_t [4] = '{32'h10000, 32'h3ff, 32'h74, 32'h10000};
    always #12.5 clk = ~clk;
    mlsd_motor_model mlsd_motor_model_i (.clk(clk), .resetn(resetn), .step_req(step_req),
        .step_load(step_load), .full_step(full_step), .load_sample(load_sample));
    mlsd_top mlsd_top_i (.clk(clk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
        .full_step(full_step), .load_sample(load_sample), .stall_flag_output(stall), .irq(irq));
    // ==========
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        check("bresp", 32'(rsp.bresp), 32'(er));
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        check("rdata", rsp.rdata, exp);
        check("rresp", 32'(rsp.rresp), 32'(er));
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic step(input logic [9:0] v);
        @(posedge clk);
        step_req <= 1'b1;
        step_load <= v;
        @(posedge clk);
        step_req <= 1'b0;
        settle();
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    // ==========
    // Tests
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rdr(REG_CTRL, 32'h0, RESP_OKAY);
        rdr(REG_VALUE, 32'h3ff, RESP_OKAY);
        rdr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
        rdr(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'h1, RESP_SLVERR);
        // Value register is read-only: the write is answered but changes nothing
        wr(REG_VALUE, 32'h0, RESP_OKAY);
        rdr(REG_VALUE, 32'h3ff, RESP_OKAY);
        $display("reset test done");
        wr(REG_IRQ_MASK, 32'h2, RESP_OKAY);
        step(10'h000);
        check("stall", 32'(stall), 32'h1);
        check("irq", 32'(irq), 32'h1);
        rdr(REG_VALUE, 32'h10000, RESP_OKAY);
        step(10'h2bc);
        check("stall", 32'(stall), 32'h0);
        rdr(REG_VALUE, 32'h2bc, RESP_OKAY);
        rdr(REG_IRQ_STATUS, 32'h3, RESP_OKAY);
        wr(REG_IRQ_STATUS, 32'h2, RESP_OKAY);
        settle();
        check("irq", 32'(irq), 32'h0);
        rdr(REG_IRQ_STATUS, 32'h1, RESP_OKAY);
        $display("stall test done");
        // Tuning pass: heavy point reads nonzero, so the host lowers the offset
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        step(10'h0a0);
        rdr(REG_VALUE, 32'h0a0, RESP_OKAY);
        wr(REG_CTRL, 32'h76, RESP_OKAY);
        step(10'h0a0);
        rdr(REG_VALUE, 32'h10000, RESP_OKAY);
        step(10'h1f4);
        rdr(REG_VALUE, 32'h154, RESP_OKAY);
        $display("tuning test done");
        for (int i = 0; i < 4; i++) begin
            wr(REG_CTRL, 32'(ofs_t[i]), RESP_OKAY);
            step(smp_t[i]);
            rdr(REG_VALUE, exp_t[i], RESP_OKAY);
        end
        $display("offset test done");
        wr(REG_CTRL, 32'h100, RESP_OKAY);
        for (int j = 1; j < 4; j++)
            step(10'(100 * j));
        rdr(REG_VALUE, 32'h10000, RESP_OKAY);
        step(10'h190);
        rdr(REG_VALUE, 32'hfa, RESP_OKAY);
        check("stall", 32'(stall), 32'h0);
        $display("filter test done");
        print_verdict();
    end
endmodule // tb_motor_load_stall_detect
